//--- rtl/fdsd_pkg.sv
// fdsd_pkg: register map, field layouts, reset values and shared types of the field display decoder
// assumes a 32-bit AXI4-Lite slave with each register on one aligned word
package fdsd_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_RANGE   = 8'h08;
  localparam logic [7:0] OFF_CHAN    = 8'h0c;
  localparam logic [7:0] OFF_PV      = 8'h10;
  localparam logic [7:0] OFF_DISP    = 8'h14;
  localparam logic [7:0] OFF_LIVE    = 8'h18;
  localparam logic [7:0] OFF_TEXT    = 8'h20;
  localparam logic [7:0] OFF_BIND    = 8'h40;
  // control fields and reset values
  localparam int CTRL_MODE_BIT   = 0;
  localparam int CTRL_NCH_LSB    = 4;
  localparam int CTRL_DWELL_LSB  = 8;
  localparam int CTRL_TLEN_LSB   = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0200;
  localparam logic [4:0]  DWELL_MIN  = 5'h02;
  localparam logic [4:0]  DWELL_MAX  = 5'h14;
  // quality thresholds
  localparam logic [7:0] QUAL_GOOD = 8'h80;
  localparam logic [7:0] QUAL_UNC  = 8'h40;
  // display geometry
  localparam int NUM_CH    = 8;
  localparam int TEXT_LEN  = 16;
  localparam int VIS_LEN   = 8;
  localparam int BAR_STEPS = 10;
  // timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int SEC_CYCLES   = CLK_HZ;
  localparam int SCROLL_MS    = 500;
  localparam int SCROLL_CYCLES = (CLK_HZ / 1000) * SCROLL_MS;
  localparam int COMM_MS      = 100;
  localparam int COMM_CYCLES  = (CLK_HZ / 1000) * COMM_MS;
  // numeric area content kinds
  typedef enum logic [1:0] {
    FDSD_NUM_ANALOG = 2'h0,
    FDSD_NUM_DIGITAL = 2'h1,
    FDSD_NUM_FAIL = 2'h2,
    FDSD_NUM_BAD = 2'h3
  } fdsd_num_kind_t;
  // published value with its quality
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  index;
    logic [15:0] value;
    logic [7:0]  quality;
  } fdsd_pub_t;
  // display outputs
  typedef struct packed {
    logic [9:0]     bar;
    logic           under_arrow;
    logic           over_arrow;
    fdsd_num_kind_t kind;
    logic [2:0]     channel;
    logic [15:0]    number;
    logic           uncertain_sym;
    logic           bad_sym;
    logic           lock_sym;
    logic           comm_sym;
  } fdsd_disp_t;
endpackage

//--- rtl/fdsd_tick.sv
// fdsd_tick: free running divider that emits a one-cycle tick every PERIOD cycles
// assumes a single clock and synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module fdsd_tick #(
  parameter int PERIOD = 100_000_000
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // tick out
  output logic      tick
);
  localparam int CW = $clog2(PERIOD + 1);
  logic [CW-1:0] cnt_reg;

  // count down to zero, reload, pulse once per period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= CW'(PERIOD - 1);
      tick    <= 1'b0;
    end else if (cnt_reg == '0) begin
      cnt_reg <= CW'(PERIOD - 1);
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
      tick    <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- rtl/fdsd_top.sv
// fdsd_top: display control of a bus-powered field indicator, registers over AXI4-Lite
// assumes published values arrive as single-cycle strobes from the fieldbus stack on aclk,
// and that the write-protect switch is an asynchronous pin
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - the bar graph shows the value from zero to one hundred percent in ten percent steps.
// - for a quality of 0x40 or more an underrange arrow lights below the configured range and an overrange arrow above it.
// - the numeric area cycles through up to eight values, each held two to twenty seconds.
// - the text area holds up to sixteen characters and scrolls as a marquee when too long.
// - a quality of 0x80 or more lights no quality symbol and leaves the display normal.
// - a quality from 0x40 up to below 0x80 lights the uncertain symbol.
// - a quality below 0x40 shows a bad marker and the channel number in the numeric area.
// - while a bad value is shown the text stays and the bar graph is blank.
// - listener mode keeps a list of live devices and binds up to eight channels by address.
// - block connection mode shows a value taken from an internal function block parameter.
// - the numeric area can show analog values, digital status and failure codes.
// - a hardware switch turns configuration write protection on or off.
module fdsd_top #(
  parameter int SEC_CYCLES    = fdsd_pkg::SEC_CYCLES,
  parameter int SCROLL_CYCLES = fdsd_pkg::SCROLL_CYCLES,
  parameter int COMM_CYCLES   = fdsd_pkg::COMM_CYCLES
) (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite write
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // fieldbus published values and function block parameter
  input  wire fdsd_pkg::fdsd_pub_t pub_data,
  input  wire logic               pub_valid,
  input  wire fdsd_pkg::fdsd_pub_t fb_data,
  input  wire logic               fb_valid,
  // write-protect switch pin
  input  wire logic               wp_switch,
  // display
  output fdsd_pkg::fdsd_disp_t    disp,
  output logic [7:0]              text_char [fdsd_pkg::VIS_LEN]
);
  localparam int NCH = fdsd_pkg::NUM_CH;
  localparam int TL  = fdsd_pkg::TEXT_LEN;

  // registers
  logic [31:0] ctrl_reg;
  logic [15:0] range_lo_reg;
  logic [15:0] range_hi_reg;
  logic [7:0]  bind_addr_reg [NCH];
  logic [7:0]  bind_idx_reg  [NCH];
  logic [1:0]  bind_kind_reg [NCH];
  logic [15:0] ch_val_reg    [NCH];
  logic [7:0]  ch_qual_reg   [NCH];
  logic [7:0]  text_reg      [TL];
  logic [255:0] live_reg;
  logic [1:0]  wp_sync_reg;
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;

  wire logic       mode_fb = ctrl_reg[fdsd_pkg::CTRL_MODE_BIT];
  wire logic [2:0] nch_m1  = ctrl_reg[fdsd_pkg::CTRL_NCH_LSB +: 3];
  wire logic [4:0] dwell_raw = ctrl_reg[fdsd_pkg::CTRL_DWELL_LSB +: 5];
  wire logic [4:0] tlen    = ctrl_reg[fdsd_pkg::CTRL_TLEN_LSB +: 5];
  wire logic       wp_on   = wp_sync_reg[1];

  // write-protect pin through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) wp_sync_reg <= 2'b00;
    else wp_sync_reg <= {wp_sync_reg[0], wp_switch};
  end

  // writable offsets; text words above 0x2c are accepted but land nowhere
  logic wr_mapped;
  always_comb begin
    wr_mapped = (aw_addr_reg == fdsd_pkg::OFF_CTRL) || (aw_addr_reg == fdsd_pkg::OFF_RANGE) ||
                (aw_addr_reg[7:4] == fdsd_pkg::OFF_TEXT[7:4]) || (aw_addr_reg[7:4] == 4'h3) ||
                (aw_addr_reg[7:5] == fdsd_pkg::OFF_BIND[7:5]);
  end

  // write channel: address and data are taken independently, response after both
  wire logic do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready;
      s_axi_wready  <= !w_hold_reg && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // protected config answers slverr; unmapped also slverr
        s_axi_bresp  <= (wp_on || !wr_mapped) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire logic cfg_we = do_write && !wp_on;

  // byte-lane merge for word registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (st[b]) r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  // control and range configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= fdsd_pkg::CTRL_RESET;
      range_lo_reg <= 16'h0000;
      range_hi_reg <= 16'h03e8;
    end else if (cfg_we && aw_addr_reg == fdsd_pkg::OFF_CTRL) begin
      ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h001f_1f71;
    end else if (cfg_we && aw_addr_reg == fdsd_pkg::OFF_RANGE) begin
      {range_hi_reg, range_lo_reg} <= merge({range_hi_reg, range_lo_reg}, w_data_reg, w_strb_reg);
    end
  end

  // per-channel bindings and captured values
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire logic [7:0] bofs = fdsd_pkg::OFF_BIND + 8'(4 * g);
      wire logic lis_hit = !mode_fb && pub_valid && pub_data.addr == bind_addr_reg[g] &&
                           pub_data.index == bind_idx_reg[g];
      wire logic fb_hit = mode_fb && fb_valid && fb_data.index == bind_idx_reg[g];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          bind_addr_reg[g] <= 8'h00;
          bind_idx_reg[g]  <= 8'h00;
          bind_kind_reg[g] <= 2'h0;
        end else if (cfg_we && aw_addr_reg == bofs) begin
          if (w_strb_reg[0]) bind_addr_reg[g] <= w_data_reg[7:0];
          if (w_strb_reg[1]) bind_idx_reg[g]  <= w_data_reg[15:8];
          if (w_strb_reg[2]) bind_kind_reg[g] <= w_data_reg[17:16];
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ch_val_reg[g]  <= 16'h0000;
          ch_qual_reg[g] <= 8'h00;
        end else if (lis_hit) begin
          ch_val_reg[g]  <= pub_data.value;
          ch_qual_reg[g] <= pub_data.quality;
        end else if (fb_hit) begin
          ch_val_reg[g]  <= fb_data.value;
          ch_qual_reg[g] <= fb_data.quality;
        end
      end
    end
    for (g = 0; g < TL; g++) begin : g_txt
      wire logic [7:0] tofs = fdsd_pkg::OFF_TEXT + 8'(g & ~3);
      always_ff @(posedge aclk) begin
        if (!aresetn) text_reg[g] <= 8'h20;
        else if (cfg_we && aw_addr_reg == tofs && w_strb_reg[g % 4])
          text_reg[g] <= w_data_reg[8*(g%4) +: 8];
      end
    end
  endgenerate

  // live list: any publisher is marked present; entries only set, a vanished device stays listed until reset
  always_ff @(posedge aclk) begin
    if (!aresetn) live_reg <= '0;
    else live_reg <= live_reg | ((pub_valid ? 256'h1 : 256'h0) << pub_data.addr);
  end

  // timers
  logic sec_tick, scroll_tick;
  fdsd_tick #(.PERIOD(SEC_CYCLES)) u_sec (.aclk(aclk), .aresetn(aresetn), .tick(sec_tick));
  fdsd_tick #(.PERIOD(SCROLL_CYCLES)) u_scr (.aclk(aclk), .aresetn(aresetn), .tick(scroll_tick));

  // clamp dwell into two to twenty seconds
  wire logic [4:0] dwell = (dwell_raw < fdsd_pkg::DWELL_MIN) ? fdsd_pkg::DWELL_MIN :
                           (dwell_raw > fdsd_pkg::DWELL_MAX) ? fdsd_pkg::DWELL_MAX : dwell_raw;

  // channel cycling
  logic [2:0] cur_reg;
  logic [4:0] dwell_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_reg       <= 3'h0;
      dwell_cnt_reg <= 5'h00;
    end else if (sec_tick) begin
      if (dwell_cnt_reg + 5'h01 >= dwell) begin
        dwell_cnt_reg <= 5'h00;
        cur_reg <= (cur_reg >= nch_m1) ? 3'h0 : cur_reg + 3'h1;
      end else begin
        dwell_cnt_reg <= dwell_cnt_reg + 5'h01;
      end
    end
  end

  // marquee offset; short text stays still
  logic [3:0] scroll_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) scroll_reg <= 4'h0;
    else if (tlen <= 5'(fdsd_pkg::VIS_LEN)) scroll_reg <= 4'h0;
    else if (scroll_tick) scroll_reg <= (5'(scroll_reg) + 5'h01 >= tlen) ? 4'h0 : scroll_reg + 4'h1;
  end

  generate
    for (g = 0; g < fdsd_pkg::VIS_LEN; g++) begin : g_vis
      wire logic [4:0] pos = 5'(scroll_reg) + 5'(g);
      always_ff @(posedge aclk) begin
        if (!aresetn) text_char[g] <= 8'h20;
        else if (pos < tlen) text_char[g] <= text_reg[pos[3:0]];
        else if (tlen > 5'(fdsd_pkg::VIS_LEN)) text_char[g] <= text_reg[4'(pos - tlen)];
        else text_char[g] <= 8'h20;
      end
    end
  endgenerate

  // communication activity stretch
  localparam int CCW = $clog2(COMM_CYCLES + 1);
  logic [CCW-1:0] comm_cnt_reg;
  wire logic rx_hit = (pub_valid && !mode_fb) || (fb_valid && mode_fb);
  always_ff @(posedge aclk) begin
    if (!aresetn) comm_cnt_reg <= '0;
    else if (rx_hit) comm_cnt_reg <= CCW'(COMM_CYCLES);
    else if (comm_cnt_reg != '0) comm_cnt_reg <= comm_cnt_reg - 1'b1;
  end

  // bar percent, range arrows, quality decode
  wire logic [15:0] cval = ch_val_reg[cur_reg];
  wire logic [7:0]  cq   = ch_qual_reg[cur_reg];
  wire logic        is_bad = cq < fdsd_pkg::QUAL_UNC;
  wire logic [15:0] span = range_hi_reg - range_lo_reg;
  wire logic [19:0] steps = (span == 16'h0) ? 20'h0 :
                            20'((32'(cval - range_lo_reg) * 32'(fdsd_pkg::BAR_STEPS)) / 32'(span));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp <= '0;
    end else begin
      disp.under_arrow   <= !is_bad && cval < range_lo_reg;
      disp.over_arrow    <= !is_bad && cval > range_hi_reg;
      disp.uncertain_sym <= cq >= fdsd_pkg::QUAL_UNC && cq < fdsd_pkg::QUAL_GOOD;
      disp.bad_sym       <= is_bad;
      disp.channel       <= cur_reg;
      disp.number        <= cval;
      disp.kind          <= is_bad ? fdsd_pkg::FDSD_NUM_BAD : fdsd_pkg::fdsd_num_kind_t'(bind_kind_reg[cur_reg]);
      disp.lock_sym      <= wp_on;
      disp.comm_sym      <= comm_cnt_reg != '0;
      if (is_bad || cval < range_lo_reg) disp.bar <= 10'h000;
      else if (cval > range_hi_reg || steps >= 20'(fdsd_pkg::BAR_STEPS)) disp.bar <= 10'h3ff;
      else disp.bar <= 10'((11'h001 << steps[3:0]) - 11'h001);
    end
  end

  // read channel: one-cycle decode, slverr on unmapped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'h0;
        case (s_axi_araddr)
          fdsd_pkg::OFF_CTRL:   s_axi_rdata <= ctrl_reg;
          fdsd_pkg::OFF_STATUS: s_axi_rdata <= {25'h0, wp_on, comm_cnt_reg != '0, is_bad, cur_reg, 1'b0};
          fdsd_pkg::OFF_RANGE:  s_axi_rdata <= {range_hi_reg, range_lo_reg};
          fdsd_pkg::OFF_CHAN:   s_axi_rdata <= {8'h0, cq, cval};
          fdsd_pkg::OFF_DISP:   s_axi_rdata <= {20'h0, disp.bar, disp.over_arrow, disp.under_arrow};
          fdsd_pkg::OFF_LIVE:   s_axi_rdata <= {24'h0, 8'(count_live(live_reg))};
          default: begin
            if (s_axi_araddr[7:4] == fdsd_pkg::OFF_TEXT[7:4] || s_axi_araddr[7:4] == 4'h3)
              s_axi_rdata <= {text_reg[{s_axi_araddr[3:2], 2'h3}], text_reg[{s_axi_araddr[3:2], 2'h2}],
                              text_reg[{s_axi_araddr[3:2], 2'h1}], text_reg[{s_axi_araddr[3:2], 2'h0}]};
            else if (s_axi_araddr[7:5] == fdsd_pkg::OFF_BIND[7:5])
              s_axi_rdata <= {14'h0, bind_kind_reg[s_axi_araddr[4:2]], bind_idx_reg[s_axi_araddr[4:2]],
                              bind_addr_reg[s_axi_araddr[4:2]]};
            else begin
              s_axi_rdata <= 32'h0000_0000;
              s_axi_rresp <= 2'h2;
            end
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // number of live devices
  function automatic int count_live(input logic [255:0] v);
    int n;
    n = 0;
    for (int i = 0; i < 256; i++) n += int'(v[i]);
    return n;
  endfunction

  // checks
  bad_blanks_bar_a: assert property (@(posedge aclk) disable iff (!aresetn)
    is_bad |=> disp.bar == 10'h000 && disp.kind == fdsd_pkg::FDSD_NUM_BAD) else $error("bad value not blanking bar");
  good_no_sym_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cq >= fdsd_pkg::QUAL_GOOD |=> !disp.uncertain_sym && !disp.bad_sym) else $error("good value lit a symbol");
  unc_sym_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cq >= 8'h40 && cq < 8'h80) |=> disp.uncertain_sym) else $error("uncertain symbol missing");
  bad_channel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    is_bad |=> disp.bad_sym && disp.channel == $past(cur_reg)) else $error("bad channel not shown");
  lock_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && wp_on |=> s_axi_bvalid && s_axi_bresp == 2'h2 && $stable(ctrl_reg)) else $error("protected write accepted");
  arrow_excl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(disp.under_arrow && disp.over_arrow)) else $error("both range arrows lit");
  comm_sym_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_hit |=> ##1 disp.comm_sym) else $error("communication symbol not lit");
  chan_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(cur_reg) |-> $past(sec_tick) && (cur_reg == 3'h0 || cur_reg == $past(cur_reg) + 3'h1)) else $error("channel step wrong");
  bar_thermo_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((disp.bar + 10'h001) & disp.bar) == 10'h000 || disp.bar == 10'h3ff) else $error("bar not ten percent steps");
endmodule
`default_nettype wire

//--- verif/fdsd_seg_model.sv
// fdsd_seg_model: fieldbus segment partner that publishes values with quality strobes
// assumes the bench calls its tasks from a process clocked by aclk
`timescale 1ns/1ps
`default_nettype none
module fdsd_seg_model (
  // clock
  input  wire logic         aclk,
  // published traffic and function block parameter
  output fdsd_pkg::fdsd_pub_t pub_data,
  output logic              pub_valid,
  output fdsd_pkg::fdsd_pub_t fb_data,
  output logic              fb_valid
);
  initial begin
    pub_data  = '0;
    pub_valid = 1'b0;
    fb_data   = '0;
    fb_valid  = 1'b0;
  end
  // one-cycle strobe; between strobes the payload is scrambled so stale data is never trusted
  task automatic send(input logic fb, input logic [7:0] a, input logic [7:0] i, input logic [15:0] v,
                      input logic [7:0] q);
    fdsd_pkg::fdsd_pub_t p;
    p = '{addr: a, index: i, value: v, quality: q};
    @(posedge aclk);
    if (fb) begin
      fb_data  <= p;
      fb_valid <= 1'b1;
    end else begin
      pub_data  <= p;
      pub_valid <= 1'b1;
    end
    @(posedge aclk);
    pub_valid <= 1'b0;
    fb_valid  <= 1'b0;
    pub_data  <= ~p;
    fb_data   <= ~p;
  endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
// tb: register-level bench of the field display decoder with a segment model
// assumes short tick periods so dwell, scroll and comm timers finish quickly
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, wp;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  fdsd_pkg::fdsd_pub_t pub_data, fb_data;
  logic pub_valid, fb_valid;
  fdsd_pkg::fdsd_disp_t disp;
  logic [7:0] text_char [fdsd_pkg::VIS_LEN];
  int err_count, checks, n;
  fdsd_top #(.SEC_CYCLES(10), .SCROLL_CYCLES(4), .COMM_CYCLES(4)) i_fdsd_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pub_data(pub_data), .pub_valid(pub_valid),
    .fb_data(fb_data), .fb_valid(fb_valid), .wp_switch(wp), .disp(disp), .text_char(text_char));
  fdsd_seg_model i_fdsd_seg_model (.aclk(aclk), .pub_data(pub_data), .pub_valid(pub_valid),
    .fb_data(fb_data), .fb_valid(fb_valid));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // write: address and data offered together, each released once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, done;
    ta = 0; tw = 0; done = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= v; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    // no cycle limit here: only the watchdog ends a wait
    while (!done) begin
      @(posedge aclk);
      if (!ta && awready) begin ta = 1; awvalid <= 1'b0; end
      if (!tw && wready) begin tw = 1; wvalid <= 1'b0; end
      if (bvalid) begin done = 1; rs = bresp; bready <= 1'b0; end
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, done;
    ta = 0; done = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (!ta && arready) begin ta = 1; arvalid <= 1'b0; end
      if (rvalid) begin done = 1; v = rdata; rs = rresp; rready <= 1'b0; end
    end
  endtask
  // send one value and let capture plus display update land
  task automatic pub(input logic fb, input logic [15:0] v, input logic [7:0] q);
    i_fdsd_seg_model.send(fb, 8'h20, 8'h01, v, q);
    repeat (3) @(posedge aclk);
    #1;
  endtask
  // wait for channel c on the display, counting edges; bounded so a stuck cycle shows as a mismatch
  task automatic wait_ch(input logic [2:0] c, output int k);
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (disp.channel != c && k < 50);
    chk({29'h0, disp.channel}, {29'h0, c});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    conclude();
  end
  initial begin
    err_count = 0; checks = 0; aresetn = 1'b0; wp = 1'b0;
    awaddr = '0; awvalid = 0; wdata = '0; wstrb = '0; wvalid = 0; bready = 0;
    araddr = '0; arvalid = 0; rready = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axr(fdsd_pkg::OFF_CTRL, d, r);
    chk(d, fdsd_pkg::CTRL_RESET);
    axr(fdsd_pkg::OFF_RANGE, d, r);
    chk(d, 32'h03e8_0000);
    chk({24'h0, text_char[0]}, 32'h0000_0020);
    axr(8'h1c, d, r);
    chk({30'h0, r}, 32'h0000_0002);
    $display("test reset and map done");
    axw(fdsd_pkg::OFF_BIND, 32'h0000_0120, r);
    chk({30'h0, r}, 32'h0000_0000);
    pub(1'b0, 16'd500, 8'h80);
    chk({22'h0, disp.bar}, 32'h0000_001f);
    chk({30'h0, disp.uncertain_sym, disp.bad_sym}, 32'h0000_0000);
    chk({31'h0, disp.comm_sym}, 32'h0000_0001);
    pub(1'b0, 16'd500, 8'h7f);
    chk({31'h0, disp.uncertain_sym}, 32'h0000_0001);
    pub(1'b0, 16'd500, 8'h40);
    chk({31'h0, disp.uncertain_sym}, 32'h0000_0001);
    pub(1'b0, 16'd500, 8'h3f);
    chk({29'h0, disp.kind, disp.bad_sym}, {29'h0, fdsd_pkg::FDSD_NUM_BAD, 1'b1});
    chk({29'h0, disp.channel}, 32'h0000_0000);
    chk({22'h0, disp.bar}, 32'h0000_0000);
    $display("test quality done");
    pub(1'b0, 16'd1200, 8'h80);
    chk({20'h0, disp.bar, disp.over_arrow, disp.under_arrow}, 32'h0000_0ffe);
    axw(fdsd_pkg::OFF_RANGE, 32'h03e8_0064, r);
    pub(1'b0, 16'd50, 8'h80);
    chk({20'h0, disp.bar, disp.over_arrow, disp.under_arrow}, 32'h0000_0001);
    pub(1'b0, 16'd1000, 8'h80);
    chk({22'h0, disp.bar}, 32'h0000_03ff);
    $display("test range done");
    axw(fdsd_pkg::OFF_CTRL, 32'h0000_0201, r);
    axw(fdsd_pkg::OFF_RANGE, 32'h03e8_0000, r);
    pub(1'b1, 16'd300, 8'h80);
    chk({22'h0, disp.bar}, 32'h0000_0007);
    $display("test block mode done");
    axw(8'h44, 32'h0001_0121, r);
    axw(fdsd_pkg::OFF_TEXT, 32'h4443_4241, r);
    axw(8'h24, 32'h4847_4645, r);
    axw(8'h28, 32'h2020_4a49, r);
    // listener mode, two channels, two second dwell, ten characters of text
    axw(fdsd_pkg::OFF_CTRL, 32'h000a_0210, r);
    chk({30'h0, r}, 32'h0000_0000);
    i_fdsd_seg_model.send(1'b0, 8'h21, 8'h01, 16'h0123, 8'h80);
    wait_ch(3'h0, n);
    wait_ch(3'h1, n);
    chk({14'h0, disp.kind, disp.number}, {14'h0, fdsd_pkg::FDSD_NUM_DIGITAL, 16'h0123});
    wait_ch(3'h0, n);
    chk(n, 32'(fdsd_pkg::DWELL_MIN) * 32'd10);
    chk({14'h0, disp.kind, disp.number}, {14'h0, fdsd_pkg::FDSD_NUM_ANALOG, 16'd300});
    axr(fdsd_pkg::OFF_LIVE, d, r);
    chk(d, 32'h0000_0002);
    $display("test channels done");
    // one scroll step every four cycles: the text moves left by one character
    @(posedge aclk);
    d = {24'h0, text_char[1]};
    repeat (4) @(posedge aclk);
    chk({24'h0, text_char[0]}, d);
    chk({31'h0, d[7:0] >= 8'h41 && d[7:0] <= 8'h4a}, 32'h0000_0001);
    $display("test marquee done");
    @(posedge aclk);
    wp <= 1'b1;
    repeat (4) @(posedge aclk);
    axw(fdsd_pkg::OFF_CTRL, 32'h0000_0300, r);
    chk({30'h0, r}, 32'h0000_0002);
    axr(fdsd_pkg::OFF_CTRL, d, r);
    chk(d, 32'h000a_0210);
    chk({31'h0, disp.lock_sym}, 32'h0000_0001);
    $display("test write protect done");
    conclude();
  end
endmodule
`default_nettype wire
